// [logic/fcr_ctrl.sv]
// Flash rewrite control: mode selection, command decoding and boot guard.
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Three modes: parallel, serial, processor rewrite.
// - Boot area is one 3.5 Kbyte division.
// - Boot area rewrite only in parallel mode.
// - Rewrite mode touches user area only.
// - Operations run via control and command registers.
// - Array not readable during rewrite mode.
// - Six software commands control program and erase.
// - Command codes; erase and reset written twice.
// - Read mode after reset and reset command.
// - Select bit enables mode; monitor flag shows it.
module fcr_ctrl #(
  parameter int ADDR_W = 16,                         // Flash address width.
  parameter int PROG_CNT = fcr_pkg::PROG_CYCLES,     // Program duration in cycles.
  parameter int ERASE_CNT = fcr_pkg::ERASE_CYCLES    // Erase duration in cycles.
) (
  input wire logic ref_clk,                 // System clock, 25 MHz.
  input wire logic reset,                   // Asynchronous reset, active high.
  input wire logic [3:0] avs_address,       // Avalon byte address.
  input wire logic avs_read,                // Avalon read strobe.
  input wire logic avs_write,               // Avalon write strobe.
  input wire logic [31:0] avs_writedata,    // Avalon write data.
  input wire logic [3:0] avs_byteenable,    // Avalon byte enables.
  output logic [31:0] avs_readdata,         // Avalon read data.
  output logic avs_waitrequest,             // Avalon wait request.
  input wire logic boot_select_pin,         // Mode strap pin, high selects boot.
  input wire logic high_program_voltage,    // High program voltage present.
  input wire logic parallel_mode_pin,       // Parallel programmer mode pin.
  input wire logic serial_mode_pin,         // Serial programmer mode pin.
  output logic cpu_fetch_blocked,           // Array closed to processor reads.
  output logic [ADDR_W-1:0] flash_addr,     // Address of the operation.
  output logic [7:0] flash_data,            // Program data byte.
  output logic flash_prog,                  // Program pulse in progress.
  output logic flash_erase,                 // Erase in progress.
  output logic flash_verify                 // Verify read mode active.
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (ADDR_W < 12 || ADDR_W > 24) begin : g_bad_addr
    $error("ADDR_W must be 12 to 24");
  end
  if (PROG_CNT < 1 || ERASE_CNT < 1) begin : g_bad_cnt
    $error("Durations must be at least one cycle");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic boot_sel_s;  // Filtered boot select.
  logic hvp_s;       // Filtered program voltage.
  logic par_s;       // Filtered parallel mode pin.
  logic ser_s;       // Filtered serial mode pin.

  fcr_sync3 u_sync_boot (.ref_clk(ref_clk), .reset(reset), .pin_in(boot_select_pin),
    .level_out(boot_sel_s));
  fcr_sync3 u_sync_hvp (.ref_clk(ref_clk), .reset(reset), .pin_in(high_program_voltage),
    .level_out(hvp_s));
  fcr_sync3 u_sync_par (.ref_clk(ref_clk), .reset(reset), .pin_in(parallel_mode_pin),
    .level_out(par_s));
  fcr_sync3 u_sync_ser (.ref_clk(ref_clk), .reset(reset), .pin_in(serial_mode_pin),
    .level_out(ser_s));

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic rewrite_sel_q;                // Rewrite mode select bit.
  logic refused_q;                    // Last request refused.
  logic [ADDR_W-1:0] addr_q;          // Target address register.
  logic [7:0] data_q;                 // Program data.
  logic prog_q;                       // Program running.
  logic erase_q;                      // Erase running.
  logic [31:0] cnt_q;                 // Operation countdown.
  logic rd_pend_q;                    // Read data loaded, the read ends this cycle.
  fcr_pkg::fcr_state_t state_q;       // Command state.
  fcr_pkg::fcr_state_t state_d;       // Next command state.
  fcr_pkg::fcr_opmode_t opmode;       // Present operating mode.

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  // Parallel mode wins over serial, which wins over processor rewrite.
  assign opmode = par_s ? fcr_pkg::FCR_OP_PARALLEL :
                  ser_s ? fcr_pkg::FCR_OP_SERIAL : fcr_pkg::FCR_OP_CPU;

  // Monitor flag: select bit set, processor mode, and voltage present.
  wire rewrite_on = rewrite_sel_q && (opmode == fcr_pkg::FCR_OP_CPU) && hvp_s;
  assign cpu_fetch_blocked = rewrite_on;

  // Boot area sits at the bottom of the array.
  wire in_boot = (32'(addr_q) < fcr_pkg::BOOT_AREA_BYTES);
  // Boot area may only change in parallel mode.
  wire boot_guard = in_boot && (opmode != fcr_pkg::FCR_OP_PARALLEL);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire busy = (state_q == fcr_pkg::FCR_ST_BUSY);
  wire hit_ctrl = (avs_address == fcr_pkg::ADDR_CTRL);
  wire hit_cmd = (avs_address == fcr_pkg::ADDR_CMD);
  wire hit_stat = (avs_address == fcr_pkg::ADDR_STAT);
  wire hit_faddr = (avs_address == fcr_pkg::ADDR_FADDR);
  wire wr_ctrl = avs_write && hit_ctrl && avs_byteenable[0];
  // Commands are only accepted when the monitor flag is on and idle.
  wire wr_cmd = avs_write && hit_cmd && avs_byteenable[0] && rewrite_on && !busy;
  wire wr_faddr = avs_write && hit_faddr;
  wire [7:0] cmd = avs_writedata[7:0];

  // Writes finish at the edge they are seen; a read waits one cycle so that the
  // registered read data already stand at the edge that ends it.
  assign avs_waitrequest = avs_read && !rd_pend_q;

  // Status word assembled from live state.
  wire [31:0] stat_word = (32'(rewrite_on) << fcr_pkg::STAT_MON_BIT)
                        | (32'(busy) << fcr_pkg::STAT_BUSY_BIT)
                        | (32'(refused_q) << fcr_pkg::STAT_REFUSE_BIT)
                        | (32'(boot_sel_s) << fcr_pkg::STAT_BOOT_BIT)
                        | (32'(state_q) << fcr_pkg::STAT_MODE_LSB);
  wire [31:0] rd_mux = hit_ctrl ? (32'(rewrite_sel_q) << fcr_pkg::CTRL_REWRITE_BIT) :
                       hit_stat ? stat_word :
                       hit_faddr ? 32'(addr_q) : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Command state machine
  // ----------------------------------------------------------------
  // Decode the next command state from the command byte written.
  always_comb begin
    state_d = state_q;
    case (state_q)
      fcr_pkg::FCR_ST_BUSY: begin
        // Countdown ends the operation and returns to read mode.
        if (cnt_q == 32'h0000_0001) begin
          state_d = fcr_pkg::FCR_ST_READ;
        end
      end
      fcr_pkg::FCR_ST_PROG: begin
        // Second cycle: data byte written to the command port starts program.
        if (wr_cmd) begin
          state_d = boot_guard ? fcr_pkg::FCR_ST_READ : fcr_pkg::FCR_ST_BUSY;
        end
      end
      fcr_pkg::FCR_ST_ERASE1: begin
        if (wr_cmd) begin
          state_d = (cmd == fcr_pkg::CMD_ERASE && !boot_guard) ?
                    fcr_pkg::FCR_ST_BUSY : fcr_pkg::FCR_ST_READ;
        end
      end
      fcr_pkg::FCR_ST_RESET1: begin
        if (wr_cmd) begin
          state_d = fcr_pkg::FCR_ST_READ;
        end
      end
      default: begin
        if (wr_cmd) begin
          if (cmd == fcr_pkg::CMD_PROG) begin
            state_d = fcr_pkg::FCR_ST_PROG;
          end else if (cmd == fcr_pkg::CMD_PVERIFY) begin
            state_d = fcr_pkg::FCR_ST_PVER;
          end else if (cmd == fcr_pkg::CMD_ERASE) begin
            state_d = fcr_pkg::FCR_ST_ERASE1;
          end else if (cmd == fcr_pkg::CMD_EVERIFY) begin
            state_d = fcr_pkg::FCR_ST_EVER;
          end else if (cmd == fcr_pkg::CMD_RESET) begin
            state_d = fcr_pkg::FCR_ST_RESET1;
          end else begin
            state_d = fcr_pkg::FCR_ST_READ;
          end
        end
      end
    endcase
    // Leaving rewrite mode drops any half-entered command.
    if (!rewrite_on && state_q != fcr_pkg::FCR_ST_BUSY) begin
      state_d = fcr_pkg::FCR_ST_READ;
    end
  end

  wire start = (state_d == fcr_pkg::FCR_ST_BUSY) && !busy;
  wire start_erase = start && (state_q == fcr_pkg::FCR_ST_ERASE1);
  wire refuse_now = wr_cmd && boot_guard &&
    (state_q == fcr_pkg::FCR_ST_PROG || state_q == fcr_pkg::FCR_ST_ERASE1);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // State, countdown and control bits.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= fcr_pkg::FCR_ST_READ;
      rewrite_sel_q <= 1'b0;
      cnt_q <= 32'h0000_0000;
      prog_q <= 1'b0;
      erase_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (wr_ctrl) begin
        rewrite_sel_q <= avs_writedata[fcr_pkg::CTRL_REWRITE_BIT];
      end
      if (start) begin
        // Hold off for the whole program or erase time.
        cnt_q <= start_erase ? 32'(ERASE_CNT) : 32'(PROG_CNT);
        prog_q <= !start_erase;
        erase_q <= start_erase;
      end else if (busy) begin
        cnt_q <= cnt_q - 32'h0000_0001;
        if (cnt_q == 32'h0000_0001) begin
          prog_q <= 1'b0;
          erase_q <= 1'b0;
        end
      end
      if (refuse_now) begin
        refused_q <= 1'b1;
      end else if (start) begin
        refused_q <= 1'b0;
      end
    end
  end

  // Address, data and read data registers.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      addr_q <= '0;
      data_q <= 8'h00;
      avs_readdata <= 32'h0000_0000;
      rd_pend_q <= 1'b0;
    end else begin
      // First cycle of a read loads the data; the second lets the read end.
      rd_pend_q <= avs_read && !rd_pend_q;
      if (wr_faddr && !busy) begin
        addr_q <= avs_writedata[ADDR_W-1:0];
      end
      if (wr_cmd && state_q == fcr_pkg::FCR_ST_PROG) begin
        data_q <= cmd;
      end
      if (avs_read && !rd_pend_q) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign flash_addr = addr_q;
  assign flash_data = data_q;
  assign flash_prog = prog_q;
  assign flash_erase = erase_q;
  assign flash_verify = (state_q == fcr_pkg::FCR_ST_PVER) || (state_q == fcr_pkg::FCR_ST_EVER);

endmodule
`default_nettype wire

// [inc/fcr_pkg.sv]
// Package with constants for the flash rewrite control block.
package fcr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;   // Control register byte address.
  localparam logic [3:0] ADDR_CMD = 4'h4;    // Command register byte address.
  localparam logic [3:0] ADDR_STAT = 4'h8;   // Status register byte address.
  localparam logic [3:0] ADDR_FADDR = 4'hC;  // Target flash address register.

  // ----------------------------------------------------------------
  // Control and status bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_REWRITE_BIT = 0;  // Rewrite mode select bit.
  localparam int STAT_MON_BIT = 0;      // Rewrite mode monitor flag.
  localparam int STAT_BUSY_BIT = 1;     // Operation in progress.
  localparam int STAT_REFUSE_BIT = 2;   // Last operation refused (boot area).
  localparam int STAT_BOOT_BIT = 3;     // Filtered level of the boot strap pin.
  localparam int STAT_MODE_LSB = 4;     // Command mode field, low bit.

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h00;     // Read.
  localparam logic [7:0] CMD_PROG = 8'h40;     // Program.
  localparam logic [7:0] CMD_PVERIFY = 8'hC0;  // Program verify.
  localparam logic [7:0] CMD_ERASE = 8'h20;    // Erase.
  localparam logic [7:0] CMD_EVERIFY = 8'hA0;  // Erase verify.
  localparam logic [7:0] CMD_RESET = 8'hFF;    // Reset.

  // ----------------------------------------------------------------
  // Operating modes and command states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FCR_OP_PARALLEL = 3'h1,
    FCR_OP_SERIAL = 3'h2,
    FCR_OP_CPU = 3'h4
  } fcr_opmode_t;

  typedef enum logic [6:0] {
    FCR_ST_READ = 7'h01,
    FCR_ST_PROG = 7'h02,
    FCR_ST_PVER = 7'h04,
    FCR_ST_ERASE1 = 7'h08,
    FCR_ST_EVER = 7'h10,
    FCR_ST_RESET1 = 7'h20,
    FCR_ST_BUSY = 7'h40
  } fcr_state_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;     // Clock rate.
  localparam int PROG_TIME_US = 20;     // Program time in microseconds.
  localparam int ERASE_TIME_MS = 20;    // Erase time in milliseconds.
  localparam int PROG_CYCLES = (PROG_TIME_US * (CLK_HZ / 1000000));
  localparam int ERASE_CYCLES = (ERASE_TIME_MS * (CLK_HZ / 1000));

  // ----------------------------------------------------------------
  // Array layout
  // ----------------------------------------------------------------
  localparam int BOOT_AREA_BYTES = 3584;  // Boot area, 3.5 Kbytes.

endpackage

// [logic/fcr_sync3.sv]
// Three-stage synchroniser for pin inputs with agreement filter.
`timescale 1ns/100ps
`default_nettype none

module fcr_sync3 (
  input wire logic ref_clk,  // System clock.
  input wire logic reset,    // Asynchronous reset, active high.
  input wire logic pin_in,   // Raw pin level.
  output var logic level_out // Filtered level.
);

  // ----------------------------------------------------------------
  // Capture chain
  // ----------------------------------------------------------------
  logic s1_q;  // First stage, read only by the second.
  logic s2_q;  // Second stage.
  logic s3_q;  // Third stage.

  // Shift the pin through three flops; take a new level once two agree.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end

endmodule
`default_nettype wire

// [verification/fcr_ctrl_assertions.sv]
// Port-level assertions for the flash rewrite control block.
`timescale 1ns/100ps
`default_nettype none

module fcr_ctrl_assertions #(
  parameter int ADDR_W = 16,  // Flash address width.
  parameter int PROG_CNT = 20,  // Program cycles.
  parameter int ERASE_CNT = 50  // Erase cycles.
) (
  input wire logic ref_clk,  // Clock.
  input wire logic reset,  // Async reset.
  input wire logic [3:0] avs_address,  // Bus address.
  input wire logic avs_write,  // Write strobe.
  input wire logic [31:0] avs_writedata,  // Write data.
  input wire logic high_program_voltage,  // Program voltage.
  input wire logic parallel_mode_pin,  // Parallel pin.
  input wire logic serial_mode_pin,  // Serial pin.
  input wire logic cpu_fetch_blocked,  // Monitor level.
  input wire logic [ADDR_W-1:0] flash_addr,  // Target.
  input wire logic [7:0] flash_data,  // Program byte.
  input wire logic flash_prog,  // Program active.
  input wire logic flash_erase  // Erase active.
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [31:0] prog_run_q;  // Cycles the program output stood high.
  logic [31:0] erase_run_q;  // Cycles the erase output stood high.
  wire cmd_wr = avs_write && (avs_address == fcr_pkg::ADDR_CMD);  // Command write taken.
  wire [7:0] wd8 = avs_writedata[7:0];  // Command byte.

  // Counts how long each operation output has stood high.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prog_run_q <= 32'h0;
      erase_run_q <= 32'h0;
    end else begin
      prog_run_q <= flash_prog ? prog_run_q + 32'h1 : 32'h0;
      erase_run_q <= flash_erase ? erase_run_q + 32'h1 : 32'h0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_mode_off;
    (parallel_mode_pin || serial_mode_pin || !high_program_voltage) [*8];
  endsequence
  sequence s_op_on;
    flash_prog || flash_erase;
  endsequence
  property p_reset_idle;
    $fell(reset) |-> !(flash_prog || flash_erase) && !cpu_fetch_blocked;
  endproperty
  property p_mon_off;
    s_mode_off |-> !cpu_fetch_blocked;
  endproperty
  property p_op_fetch;
    s_op_on |-> cpu_fetch_blocked;
  endproperty
  property p_boot_guard;
    s_op_on |-> (int'(flash_addr) >= fcr_pkg::BOOT_AREA_BYTES);
  endproperty
  property p_prog_cause;
    $rose(flash_prog) |-> $past(cmd_wr) && (flash_data == $past(wd8));
  endproperty
  property p_erase_cause;
    $rose(flash_erase) |-> $past(cmd_wr) && ($past(wd8) == fcr_pkg::CMD_ERASE);
  endproperty
  property p_prog_len;
    $fell(flash_prog) |-> prog_run_q == PROG_CNT;
  endproperty
  property p_erase_len;
    $fell(flash_erase) |-> erase_run_q == ERASE_CNT;
  endproperty

  a_reset_idle: assert property (p_reset_idle)
    else $error("operation output high out of reset");
  a_mon_off: assert property (p_mon_off)
    else $error("monitor set outside processor mode");
  a_op_fetch: assert property (p_op_fetch)
    else $error("array open during operation");
  a_boot_guard: assert property (p_boot_guard)
    else $error("operation on boot area");
  a_prog_cause: assert property (p_prog_cause)
    else $error("program start without data write");
  a_erase_cause: assert property (p_erase_cause)
    else $error("erase start without second erase code");
  a_prog_len: assert property (p_prog_len)
    else $error("program length wrong");
  a_erase_len: assert property (p_erase_len)
    else $error("erase length wrong");
endmodule

`default_nettype wire

// [verification/fcr_cpu_model.sv]
// Processor-side bus model reaching the flash control registers.
`timescale 1ns/100ps
`default_nettype none

module fcr_cpu_model (
  input wire logic ref_clk,  // System clock.
  output var logic [3:0] avs_address,  // Byte address.
  output var logic avs_read,  // Read strobe.
  output var logic avs_write,  // Write strobe.
  output var logic [31:0] avs_writedata,  // Write data.
  output var logic [3:0] avs_byteenable,  // Byte enables.
  input wire logic [31:0] avs_readdata,  // Read data.
  input wire logic avs_waitrequest  // Slave stall.
);
  // Idle bus at time zero.
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end

  // Holds a request until the slave stops waiting, takes read data there, then releases.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;  // Read data stand at the accepting edge.
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_writedata <= ~d;  // Released data shows no stale value.
    @(posedge ref_clk);
  endtask

  // Register write; select bit, target address and commands go through register accesses.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  // Register read; data is taken at the edge that ends the read.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask

  // Sets the select bit and reports the monitor flag.
  task automatic enter(output logic ok);
    logic [31:0] s;
    wr(fcr_pkg::ADDR_CTRL, 32'h1);
    rd(fcr_pkg::ADDR_STAT, s);
    ok = s[fcr_pkg::STAT_MON_BIT];
  endtask

  // Polls until the running operation has ended.
  task automatic wait_idle(output logic [31:0] s);
    s = 32'h2;
    for (int i = 0; i < 200 && s[fcr_pkg::STAT_BUSY_BIT] !== 1'b0; i++) begin
      rd(fcr_pkg::ADDR_STAT, s);
    end
  endtask
endmodule

`default_nettype wire

// [verification/tb_cpu_flash_rewrite_control.sv]
// Self-checking bench for the flash rewrite control block.
`timescale 1ns/100ps
`default_nettype none

module tb_cpu_flash_rewrite_control;
  localparam int BOOT = fcr_pkg::BOOT_AREA_BYTES;  // First user address.
  logic ref_clk = 1'b0;  // System clock.
  logic reset = 1'b1;  // Reset, held at start.
  logic hpv = 1'b0;  // Program voltage present.
  logic par_pin = 1'b0;  // Parallel mode pin.
  logic ser_pin = 1'b0;  // Serial mode pin.
  logic sel_pin = 1'b0;  // Boot strap pin.
  wire [3:0] addr, be;  // Bus address and enables.
  wire rd_s, wr_s, waitreq, blocked, prog, erase, verify;  // Strobes and levels.
  wire [31:0] wdata, rdata;  // Bus data.
  wire [15:0] faddr;  // Operation address.
  wire [7:0] fdata;  // Program byte.
  int mismatches = 0;  // Failed comparisons.
  int n_compared = 0;  // All comparisons.
  logic [31:0] lfsr_q = 32'h171E0;  // Random source.
  logic [31:0] s;  // Last status read.
  logic ok;  // Monitor flag seen.
  logic [15:0] a;  // Target address.
  logic [7:0] codes [9] = '{8'hC0, 8'hA0, 8'h00, 8'hFF, 8'hFF, 8'h20, 8'h00, 8'h40, 8'h3C};
  logic [6:0] states [9] = '{7'h04, 7'h10, 7'h01, 7'h20, 7'h01, 7'h08, 7'h01, 7'h02, 7'h40};

  always #20 ref_clk = ~ref_clk;  // 25 MHz clock.

  fcr_ctrl #(.PROG_CNT(20), .ERASE_CNT(50)) DUT (.ref_clk(ref_clk), .reset(reset),
    .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .boot_select_pin(sel_pin), .high_program_voltage(hpv), .parallel_mode_pin(par_pin),
    .serial_mode_pin(ser_pin), .cpu_fetch_blocked(blocked), .flash_addr(faddr),
    .flash_data(fdata), .flash_prog(prog), .flash_erase(erase), .flash_verify(verify));
  fcr_cpu_model cpu (.ref_clk(ref_clk), .avs_address(addr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitreq));

  // Steps the random source.
  function automatic logic [31:0] rnd(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Expected status word from state field and monitor flag.
  function automatic logic [31:0] stat(input logic [6:0] st, input logic mon);
    return {21'h0, st, 3'h0, mon};
  endfunction

  // Compares one result and counts it.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Requests a program or erase and follows it to its end; a boot area target must be refused.
  task automatic op(input logic [15:0] t, input logic er, input logic [7:0] d);
    logic go;
    go = (t >= BOOT);
    cpu.wr(fcr_pkg::ADDR_FADDR, {16'h0, t});
    cpu.wr(fcr_pkg::ADDR_CMD, er ? 32'h20 : 32'h40);
    cpu.wr(fcr_pkg::ADDR_CMD, er ? 32'h20 : {24'h0, d});
    cmp({erase, prog}, go ? {er, !er} : 2'b00);
    if (go) cmp(faddr, t);
    if (go && !er) cmp(fdata, d);
    if (go) cpu.wr(fcr_pkg::ADDR_CMD, 32'hFF);
    cpu.wait_idle(s);
    cmp(s & (go ? 32'h7F3 : 32'h7F7), stat(7'h01, 1'b1) | {29'h0, !go, 2'h0});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (6) @(posedge ref_clk);
    cpu.rd(fcr_pkg::ADDR_STAT, s);
    cmp(s & 32'h7F3, stat(7'h01, 1'b0));
    cpu.rd(4'h2, s);
    cmp(s, 32'h0);
    cpu.wr(fcr_pkg::ADDR_CMD, 32'h40);
    cpu.wr(fcr_pkg::ADDR_CMD, 32'h5A);
    cmp(prog, 1'b0);
    $display("test idle done");
    hpv <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      par_pin <= (m == 1);
      ser_pin <= (m == 2);
      sel_pin <= (m == 3);
      repeat (10) @(posedge ref_clk);
      cpu.enter(ok);
      cmp(ok, m == 0 || m == 3);
      cmp(blocked, m == 0 || m == 3);
    end
    cpu.rd(fcr_pkg::ADDR_STAT, s);
    cmp(s[fcr_pkg::STAT_BOOT_BIT], 1'b1);
    $display("test modes done");
    cpu.wr(fcr_pkg::ADDR_FADDR, 32'h1000);
    for (int i = 0; i < 9; i++) begin
      cpu.wr(fcr_pkg::ADDR_CMD, {24'h0, codes[i]});
      cpu.rd(fcr_pkg::ADDR_STAT, s);
      cmp(s & 32'h7F1, stat(states[i], 1'b1));
      cmp(verify, states[i] == 7'h04 || states[i] == 7'h10);
    end
    cpu.wait_idle(s);
    $display("test commands done");
    for (int i = 0; i < 10; i++) begin
      lfsr_q = rnd(lfsr_q);
      a = i[0] ? 16'(lfsr_q[15:0] % BOOT) : 16'(BOOT + lfsr_q[15:0] % (65536 - BOOT));
      if (i < 2) a = i[0] ? 16'(BOOT - 1) : 16'(BOOT);
      op(a, i[1], lfsr_q[27:20]);
    end
    $display("test operations done");
    results();
  end

  // Cuts a hang short long after the tests should have ended.
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    results();
  end
endmodule

bind fcr_ctrl fcr_ctrl_assertions #(.ADDR_W(ADDR_W), .PROG_CNT(PROG_CNT),
  .ERASE_CNT(ERASE_CNT)) u_chk (.ref_clk(ref_clk), .reset(reset),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .high_program_voltage(high_program_voltage), .parallel_mode_pin(parallel_mode_pin),
  .serial_mode_pin(serial_mode_pin), .cpu_fetch_blocked(cpu_fetch_blocked),
  .flash_addr(flash_addr), .flash_data(flash_data), .flash_prog(flash_prog),
  .flash_erase(flash_erase));

`default_nettype wire
